// File: design/ctw_calendar.sv
`timescale 1ns/10ps
module ctw_calendar (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_osc_en,          // 32.768 kHz tick enable
    input  wire logic                i_power_on_flag,   // power-on default request
    input  wire ctw_pkg::ctw_wr_t    i_wr,              // register write strobe
    input  wire logic [3:0]          i_rd_addr,         // register read address
    input  wire logic [6:0]          i_seconds,         // bcd seconds counter
    input  wire logic                i_day_carry,       // hour counter carry
    input  wire ctw_pkg::ctw_time_t  i_now,             // current minute, hour and weekday
    input  wire logic                i_weekly_alarm_enable,
    output logic [7:0]               o_rd_data,         // registered read data
    output logic                     o_sec_tick,        // seconds carry
    output logic                     o_subclk,          // raw tick, one cycle late
    output logic [2:0]               o_weekday,         // day-of-week count
    output logic [5:0]               o_day,             // day-of-month count
    output logic                     o_weekly_alarm_flag_set  // one-cycle set pulse
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // bcd increment of a two-digit value, no wrap handling
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    // leap when bcd year divisible by four, 00 included
    function automatic logic is_leap(input logic [7:0] y);
        if (!y[4]) begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
    endfunction : is_leap

    // last valid bcd day of a month
    function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
        case (m)
            5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
            5'h02:                      last_day = is_leap(y) ? 6'h29 : 6'h28;
            default:                    last_day = 6'h31;
        endcase
    endfunction : last_day

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [2:0]  weekday_ff;      // day-of-week count
    logic [5:0]  day_ff;          // bcd day of month
    logic [4:0]  month_ff;        // bcd month, tens bit at 4
    logic        century_ff;      // century bit
    logic [7:0]  year_ff;         // bcd year
    logic [6:0]  trim_ff;         // direction plus six magnitude bits
    logic        trim_active_ff;  // armed by a trim write
    logic        trim_skip_ff;    // trim written during this second
    logic [6:0]  wa_min_ff;       // alarm minute
    logic [5:0]  wa_hour_ff;      // alarm hour
    logic [6:0]  wa_days_ff;      // weekday enables
    logic        match_ff;        // previous match state
    logic [11:0] alm_cnt_ff;      // delay counter
    ctw_pkg::ctw_alm_state_t alm_state_ff;
    ctw_pkg::ctw_alm_state_t nxt_alm_state;

    logic        sec_tick;        // seconds carry from divider
    logic        day_wrap;        // last day reached on carry
    logic        month_wrap;      // december rolls over
    logic        year_wrap;       // 99 rolls over
    logic        match;           // weekly alarm comparison

    logic wr_weekday;
    logic wr_day;
    logic wr_month;
    logic wr_year;
    logic wr_trim;
    logic wr_sec;

    assign wr_weekday = i_wr.en && (i_wr.addr == ctw_pkg::ADDR_WEEKDAY);
    assign wr_day     = i_wr.en && (i_wr.addr == ctw_pkg::ADDR_DAY);
    assign wr_month   = i_wr.en && (i_wr.addr == ctw_pkg::ADDR_MONTH);
    assign wr_year    = i_wr.en && (i_wr.addr == ctw_pkg::ADDR_YEAR);
    assign wr_trim    = i_wr.en && (i_wr.addr == ctw_pkg::ADDR_TRIM);
    assign wr_sec     = i_wr.en && (i_wr.addr == ctw_pkg::ADDR_SECONDS);

    // ----------------------------------------------------------------
    // carry chain decode
    // ----------------------------------------------------------------
    // month dependent limit
    assign day_wrap   = i_day_carry && (day_ff == last_day(month_ff, year_ff));
    assign month_wrap = day_wrap && (month_ff == ctw_pkg::MONTH_LAST);
    assign year_wrap  = month_wrap && (year_ff == ctw_pkg::YEAR_LAST);

    // ----------------------------------------------------------------
    // day-of-week counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            weekday_ff <= 3'h0;
        end else if (wr_weekday) begin
            // write beats a same-cycle carry
            weekday_ff <= i_wr.data[2:0];
        end else if (i_day_carry) begin
            weekday_ff <= (weekday_ff >= ctw_pkg::WEEKDAY_LAST) ? 3'h0 : weekday_ff + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // day-of-month counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            day_ff <= ctw_pkg::DAY_FIRST;
        end else if (wr_day) begin
            day_ff <= i_wr.data[5:0];
        end else if (day_wrap) begin
            day_ff <= ctw_pkg::DAY_FIRST;
        end else if (i_day_carry) begin
            // a nonexistent date may run off; host keeps dates valid
            day_ff <= 6'(bcd_inc({2'b00, day_ff}));
        end
    end

    // ----------------------------------------------------------------
    // month counter and century bit
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            month_ff   <= ctw_pkg::MONTH_FIRST;
            century_ff <= 1'b0;
        end else if (wr_month) begin
            month_ff   <= i_wr.data[4:0];
            century_ff <= i_wr.data[ctw_pkg::CENTURY_BIT];
        end else if (day_wrap) begin
            if (month_wrap) begin
                month_ff <= ctw_pkg::MONTH_FIRST;
            end else begin
                month_ff <= 5'(bcd_inc({3'b000, month_ff}));
            end
            if (year_wrap) begin
                century_ff <= ~century_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // year counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            year_ff <= 8'h00;
        end else if (wr_year) begin
            year_ff <= i_wr.data;
        end else if (month_wrap) begin
            year_ff <= year_wrap ? 8'h00 : bcd_inc(year_ff);
        end
    end

    // ----------------------------------------------------------------
    // trim register and its arming
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trim_ff        <= ctw_pkg::TRIM_RESET;
            trim_active_ff <= 1'b0;
        end else if (i_power_on_flag) begin
            // power-on defaults clear the trim
            trim_ff        <= ctw_pkg::TRIM_RESET;
            trim_active_ff <= 1'b0;
        end else if (wr_trim) begin
            trim_ff        <= i_wr.data[6:0];
            trim_active_ff <= 1'b1;
        end
    end

    // skip flag: a write during a trim second cancels that trim;
    // set wins over the clear from the seconds carry
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trim_skip_ff <= 1'b0;
        end else if (wr_trim) begin
            trim_skip_ff <= 1'b1;
        end else if (sec_tick) begin
            trim_skip_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // seconds divider
    // ----------------------------------------------------------------
    // lengthen and shorten paths inside divider
    ctw_sec_divider u_div (
        .i_clk         (i_clk),
        .i_rst_n       (i_rst_n),
        .i_osc_en      (i_osc_en),
        .i_clear       (wr_sec),
        .i_trim        (trim_ff),
        .i_trim_active (trim_active_ff),
        .i_skip        (trim_skip_ff),
        .i_seconds     (i_seconds),
        .o_sec_tick    (sec_tick)
    );

    // raw tick forwarded; trimming never touches it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_subclk   <= 1'b0;
            o_sec_tick <= 1'b0;
        end else begin
            o_subclk   <= i_osc_en;
            o_sec_tick <= sec_tick;
        end
    end

    // ----------------------------------------------------------------
    // weekly alarm registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wa_min_ff  <= 7'h00;
            wa_hour_ff <= 6'h00;
            wa_days_ff <= 7'h00;
        end else if (i_wr.en) begin
            case (i_wr.addr)
                ctw_pkg::ADDR_WA_MIN:  wa_min_ff  <= i_wr.data[6:0];
                ctw_pkg::ADDR_WA_HOUR: wa_hour_ff <= i_wr.data[5:0];
                ctw_pkg::ADDR_WA_DAYS: wa_days_ff <= i_wr.data[6:0];
                default: begin
                    wa_min_ff <= wa_min_ff;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // weekly alarm match
    // ----------------------------------------------------------------
    // same encoding as hour counter, raw compare
    assign match = i_weekly_alarm_enable && (wa_days_ff != 7'h00) &&
                   (i_now.weekday <= ctw_pkg::WEEKDAY_LAST) && wa_days_ff[i_now.weekday] &&
                   (i_now.minute == wa_min_ff) && (i_now.hour == wa_hour_ff);

    // next state: a fresh match starts the delay
    always_comb begin
        nxt_alm_state = alm_state_ff;
        case (alm_state_ff)
            ctw_pkg::ALM_IDLE: begin
                if (match && !match_ff) begin
                    nxt_alm_state = ctw_pkg::ALM_WAIT;
                end
            end
            ctw_pkg::ALM_WAIT: begin
                // dropping the enable abandons the pending flag
                if (!i_weekly_alarm_enable ||
                    (alm_cnt_ff == 12'(ctw_pkg::ALARM_DELAY_CYC - 1))) begin
                    nxt_alm_state = ctw_pkg::ALM_IDLE;
                end
            end
            default: begin
                nxt_alm_state = ctw_pkg::ALM_IDLE;
            end
        endcase
    end

    // state, edge memory and delay counter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alm_state_ff            <= ctw_pkg::ALM_IDLE;
            match_ff                <= 1'b0;
            alm_cnt_ff              <= 12'h000;
            o_weekly_alarm_flag_set <= 1'b0;
        end else begin
            alm_state_ff            <= nxt_alm_state;
            match_ff                <= match;
            o_weekly_alarm_flag_set <= 1'b0;
            if (alm_state_ff == ctw_pkg::ALM_WAIT) begin
                alm_cnt_ff <= alm_cnt_ff + 12'h001;
                if (i_weekly_alarm_enable &&
                    (alm_cnt_ff == 12'(ctw_pkg::ALARM_DELAY_CYC - 1))) begin
                    o_weekly_alarm_flag_set <= 1'b1;
                end
            end else begin
                alm_cnt_ff <= 12'h000;
            end
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 8'h00;
        end else begin
            case (i_rd_addr)
                ctw_pkg::ADDR_WEEKDAY: o_rd_data <= {5'h00, weekday_ff};
                ctw_pkg::ADDR_DAY:     o_rd_data <= {2'b00, day_ff};
                ctw_pkg::ADDR_MONTH:   o_rd_data <= {century_ff, 2'b00, month_ff};
                ctw_pkg::ADDR_YEAR:    o_rd_data <= year_ff;
                ctw_pkg::ADDR_TRIM:    o_rd_data <= {1'b0, trim_ff};
                ctw_pkg::ADDR_WA_MIN:  o_rd_data <= {1'b0, wa_min_ff};
                ctw_pkg::ADDR_WA_HOUR: o_rd_data <= {2'b00, wa_hour_ff};
                ctw_pkg::ADDR_WA_DAYS: o_rd_data <= {1'b0, wa_days_ff};
                default:               o_rd_data <= 8'h00;
            endcase
        end
    end

    // counters exposed to the neighbouring time-of-day logic
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_weekday <= 3'h0;
            o_day     <= ctw_pkg::DAY_FIRST;
        end else begin
            o_weekday <= weekday_ff;
            o_day     <= day_ff;
        end
    end

endmodule : ctw_calendar

// File: design/ctw_pkg.sv
package ctw_pkg;

    // ----------------------------------------------------------------
    // register addresses on the four-bit register pointer
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_SECONDS  = 4'h0;     // seconds counter, lives outside
    localparam logic [3:0] ADDR_WEEKDAY  = 4'h3;     // day-of-week counter
    localparam logic [3:0] ADDR_DAY      = 4'h4;     // day-of-month counter
    localparam logic [3:0] ADDR_MONTH    = 4'h5;     // month_century
    localparam logic [3:0] ADDR_YEAR     = 4'h6;     // year_count
    localparam logic [3:0] ADDR_TRIM     = 4'h7;     // time_trim
    localparam logic [3:0] ADDR_WA_MIN   = 4'h8;     // weekly_alarm_minute
    localparam logic [3:0] ADDR_WA_HOUR  = 4'h9;     // weekly_alarm_hour
    localparam logic [3:0] ADDR_WA_DAYS  = 4'hA;     // weekly_alarm_days

    // ----------------------------------------------------------------
    // field positions and implemented-bit masks
    // ----------------------------------------------------------------
    localparam int         CENTURY_BIT   = 7;        // century bit in month_century
    localparam int         TRIM_DIR_BIT  = 6;        // trim_direction
    localparam logic [7:0] MASK_WEEKDAY  = 8'h07;
    localparam logic [7:0] MASK_DAY      = 8'h3F;
    localparam logic [7:0] MASK_MONTH    = 8'h9F;
    localparam logic [7:0] MASK_TRIM     = 8'h7F;
    localparam logic [7:0] MASK_WA_MIN   = 8'h7F;
    localparam logic [7:0] MASK_WA_HOUR  = 8'h3F;
    localparam logic [7:0] MASK_WA_DAYS  = 8'h7F;

    // ----------------------------------------------------------------
    // values after reset and calendar limits
    // ----------------------------------------------------------------
    localparam logic [6:0] TRIM_RESET    = 7'h00;
    localparam logic [2:0] WEEKDAY_LAST  = 3'h6;     // 110 wraps to 000
    localparam logic [4:0] MONTH_LAST    = 5'h12;    // bcd 12
    localparam logic [4:0] MONTH_FIRST   = 5'h01;
    localparam logic [7:0] YEAR_LAST     = 8'h99;
    localparam logic [5:0] DAY_FIRST     = 6'h01;
    localparam logic [6:0] SEC_TRIM_A    = 7'h00;    // trimmed seconds
    localparam logic [6:0] SEC_TRIM_B    = 7'h20;
    localparam logic [6:0] SEC_TRIM_C    = 7'h40;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam logic [15:0] SEC_PERIOD_OSC   = 16'h8000;  // 32768 oscillator ticks
    localparam int          CLK_PERIOD_NS    = 20;
    localparam int          ALARM_DELAY_NS   = 61000;     // 61 us
    // least time: rounded up to whole cycles
    localparam int          ALARM_DELAY_CYC  = (ALARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       en;       // one-cycle write strobe
        logic [3:0] addr;     // register address
        logic [7:0] data;     // write data
    } ctw_wr_t;

    typedef struct packed {
        logic [6:0] minute;   // bcd minutes
        logic [5:0] hour;     // bcd hours, bit 5 pm or tens-20
        logic [2:0] weekday;  // day-of-week count
    } ctw_time_t;

    typedef enum logic [1:0] {
        ALM_IDLE = 2'b01,
        ALM_WAIT = 2'b10
    } ctw_alm_state_t;

endpackage : ctw_pkg

// File: design/ctw_sec_divider.sv
`timescale 1ns/10ps
module ctw_sec_divider (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_osc_en,       // one 32.768 kHz tick
    input  wire logic       i_clear,        // seconds written
    input  wire logic [6:0] i_trim,         // trim value
    input  wire logic       i_trim_active,  // trimming armed
    input  wire logic       i_skip,         // trim written this second
    input  wire logic [6:0] i_seconds,      // current bcd seconds
    output logic            o_sec_tick      // one-cycle seconds carry
);

    // ----------------------------------------------------------------
    // trimmed second length
    // ----------------------------------------------------------------
    function automatic logic [15:0] period_of(input logic [6:0] trim);
        logic [15:0] mag2;
        mag2 = 16'h0000;
        if (trim[5:0] == 6'h00) begin
            period_of = ctw_pkg::SEC_PERIOD_OSC;
        end else if (!trim[ctw_pkg::TRIM_DIR_BIT]) begin
            // lengthen by (value - 1) * 2
            mag2      = {9'h000, trim[5:0] - 6'h01, 1'b0};
            period_of = ctw_pkg::SEC_PERIOD_OSC + mag2;
        end else begin
            // shorten by (~value + 1) * 2
            mag2      = {9'h000, (~trim[5:0]) + 6'h01, 1'b0};
            period_of = ctw_pkg::SEC_PERIOD_OSC - mag2;
        end
    endfunction : period_of

    logic [15:0] cnt_ff;      // oscillator ticks in this second
    logic [15:0] period;      // ticks that end this second
    logic        trim_point;  // second starts at 00, 20 or 40

    assign trim_point = (i_seconds == ctw_pkg::SEC_TRIM_A) || (i_seconds == ctw_pkg::SEC_TRIM_B) ||
                        (i_seconds == ctw_pkg::SEC_TRIM_C);
    assign period = (trim_point && i_trim_active && !i_skip) ? period_of(i_trim) : ctw_pkg::SEC_PERIOD_OSC;

    // ----------------------------------------------------------------
    // tick counter; only seconds chain, raw tick untouched
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff     <= 16'h0000;
            o_sec_tick <= 1'b0;
        end else begin
            o_sec_tick <= 1'b0;
            if (i_clear) begin
                cnt_ff <= 16'h0000;
            end else if (i_osc_en) begin
                if (cnt_ff >= period - 16'h0001) begin
                    cnt_ff     <= 16'h0000;
                    o_sec_tick <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end
        end
    end

endmodule : ctw_sec_divider

// File: bench/ctw_calendar_asserts.sv
`timescale 1ns/10ps
module ctw_calendar_asserts (
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire logic             i_osc_en,
    input wire ctw_pkg::ctw_wr_t i_wr,
    input wire logic [3:0]       i_rd_addr,
    input wire logic             i_day_carry,
    input wire logic             i_weekly_alarm_enable,
    input wire logic [7:0]       o_rd_data,
    input wire logic             o_sec_tick,
    input wire logic             o_subclk,
    input wire logic [2:0]       o_weekday,
    input wire logic [5:0]       o_day,
    input wire logic             o_weekly_alarm_flag_set
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_sub; i_osc_en |=> o_subclk; endproperty
    a_sub: assert property (p_sub) else $error("subclock tick lost");
    property p_sec; o_sec_tick |-> $past(i_osc_en, 2) ##1 !o_sec_tick; endproperty
    a_sec: assert property (p_sec) else $error("seconds carry malformed");
    property p_clr; i_wr.en && i_wr.addr == 4'h0 |-> ##3 !o_sec_tick [*8]; endproperty
    a_clr: assert property (p_clr) else $error("divider not restarted");
    property p_wd; $changed(o_weekday) && !$past(i_wr.en, 2)
        |-> o_weekday == ($past(o_weekday) == 3'h6 ? 3'h0 : $past(o_weekday) + 3'h1); endproperty
    a_wd: assert property (p_wd) else $error("weekday step wrong");
    property p_day; $changed(o_day) && !$past(i_wr.en, 2) |-> $past(i_day_carry, 2); endproperty
    a_day: assert property (p_day) else $error("day moved without carry");
    property p_wrap; $changed(o_day) && o_day == 6'h01 && !$past(i_wr.en, 2)
        |-> $past(o_day) inside {6'h28, 6'h29, 6'h30, 6'h31}; endproperty
    a_wrap: assert property (p_wrap) else $error("day wrapped early");
    property p_rd0; $past(i_rd_addr) > 4'hA |-> o_rd_data == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
    property p_alm; o_weekly_alarm_flag_set |-> $past(i_weekly_alarm_enable) ##1 !o_weekly_alarm_flag_set; endproperty
    a_alm: assert property (p_alm) else $error("alarm pulse malformed");
endmodule : ctw_calendar_asserts
bind ctw_calendar ctw_calendar_asserts ctw_calendar_asserts_i (.i_clk, .i_rst_n, .i_osc_en, .i_wr, .i_rd_addr,
    .i_day_carry, .i_weekly_alarm_enable, .o_rd_data, .o_sec_tick, .o_subclk, .o_weekday, .o_day,
    .o_weekly_alarm_flag_set);

// File: bench/ctw_host_model.sv
`timescale 1ns/10ps
module ctw_host_model (
    input wire logic         i_clk,
    input wire logic [7:0]   i_rd_data,
    output ctw_pkg::ctw_wr_t o_wr,
    output logic [3:0]       o_rd_addr
);
    initial o_wr = '0;
    initial o_rd_addr = 4'h0;
    // no carry or match sees a false value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_wr = '{1'b1, a, (a == 4'h7) ? (d & 8'h7F) : d};
        @(negedge i_clk);
        o_wr = '{1'b0, a, ~d};
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(negedge i_clk);
        o_rd_addr = a;
        @(negedge i_clk);
        q = i_rd_data;
    endtask : rd
endmodule : ctw_host_model

// File: bench/calendar_trim_weekly_alarm_tb.sv
`timescale 1ns/10ps
module calendar_trim_weekly_alarm_tb;
    logic clk = 1'b0, rst_n = 1'b0, osc = 1'b0, carry = 1'b0, alm_en = 1'b0;
    ctw_pkg::ctw_wr_t wr;
    ctw_pkg::ctw_time_t now = '0;
    logic [3:0] rd_addr;
    logic [7:0] rd_data, q;
    logic sec_tick, flag_set;
    logic [2:0] wd;
    logic [5:0] day;
    int n_fail = 0, checks_done = 0, cyc = 0, t0;
    initial forever #10 clk = ~clk;
    ctw_host_model host_i (.i_clk(clk), .i_rd_data(rd_data), .o_wr(wr), .o_rd_addr(rd_addr));
    ctw_calendar ctw_calendar_i (.i_clk(clk), .i_rst_n(rst_n), .i_osc_en(osc), .i_power_on_flag(1'b0),
        .i_wr(wr), .i_rd_addr(rd_addr), .i_seconds(7'h00), .i_day_carry(carry), .i_now(now),
        .i_weekly_alarm_enable(alm_en), .o_rd_data(rd_data), .o_sec_tick(sec_tick), .o_subclk(),
        .o_weekday(wd), .o_day(day), .o_weekly_alarm_flag_set(flag_set));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cal(input logic [7:0] w, d, mo, y, ed, emo, ey);
        host_i.wr(4'h3, w);
        host_i.wr(4'h4, d);
        host_i.wr(4'h5, mo);
        host_i.wr(4'h6, y);
        carry = 1'b1;
        @(negedge clk) carry = 1'b0;
        repeat (2) @(negedge clk);
        chk({5'h00, wd}, (w == 8'h06) ? 8'h00 : w + 8'h01);
        chk({2'b00, day}, ed);
        host_i.rd(4'h5, q);
        chk(q, emo);
        host_i.rd(4'h6, q);
        chk(q, ey);
    endtask : cal
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // whole run is near 72000 cycles, the two trim-test seconds dominate
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // trim reset value and unimplemented bits
    task automatic test_regs;
        host_i.rd(4'h7, q);
        chk(q, 8'h00);
        for (int i = 5; i < 16; i += 5) begin
            host_i.wr(4'(i), 8'hFF);
            host_i.rd(4'(i), q);
            chk(q, (i == 5) ? 8'h9F : (i == 10) ? 8'h7F : 8'h00);
        end
        $display("register test done");
    endtask : test_regs
    // day, month, year and century carries
    task automatic test_calendar;
        cal(8'h06, 8'h28, 8'h02, 8'h23, 8'h01, 8'h03, 8'h23);
        cal(8'h00, 8'h28, 8'h02, 8'h24, 8'h29, 8'h02, 8'h24);
        cal(8'h01, 8'h30, 8'h04, 8'h00, 8'h01, 8'h05, 8'h00);
        cal(8'h02, 8'h31, 8'h12, 8'h99, 8'h01, 8'h81, 8'h00);
        $display("calendar test done");
    endtask : test_calendar
    // skipped first second, then a shortened one
    task automatic test_trim;
        osc = 1'b1;
        host_i.wr(4'h7, 8'h7E);
        host_i.wr(4'h0, 8'h00);
        t0 = cyc;
        @(posedge sec_tick);
        chk(8'(cyc - t0 > 32767 && cyc - t0 < 32772), 8'h01);
        t0 = cyc;
        @(posedge sec_tick);
        chk(8'(cyc - t0 - 32700), 8'h40);
        osc = 1'b0;
        $display("trim test done");
    endtask : test_trim
    // no weekday bits first, then one enabled day
    task automatic test_alarm;
        now = '{7'h30, 6'h32, 3'h1};
        alm_en = 1'b1;
        host_i.wr(4'hA, 8'h00);
        host_i.wr(4'h8, 8'h30);
        host_i.wr(4'h9, 8'h32);
        t0 = 0;
        repeat (3200) @(negedge clk) t0 += flag_set;
        chk(8'(t0), 8'h00);
        host_i.wr(4'hA, 8'h02);
        t0 = cyc;
        @(posedge flag_set);
        chk(8'(cyc - t0 > 3050 && cyc - t0 < 3055), 8'h01);
        $display("alarm test done");
    endtask : test_alarm
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        test_regs();
        test_calendar();
        test_trim();
        test_alarm();
        tally_and_finish();
    end
endmodule : calendar_trim_weekly_alarm_tb
